// ### core/icsd_pkg.sv
// constants shared by the i/o cell storage logic
package icsd_pkg;
   localparam int          NUM_ELEM      = 6;
   localparam int          NUM_CLK       = 4;
   localparam int          CFG_W         = 4;
   // register byte offsets
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_ELEM     = 8'h04;
   localparam logic [7:0]  ADDR_INIT     = 8'h08;
   localparam logic [7:0]  ADDR_INV      = 8'h0C;
   localparam logic [7:0]  ADDR_STAT     = 8'h10;
   // control register fields
   localparam int          CTRL_OUT_DDR  = 0;
   localparam int          CTRL_OE_DDR   = 1;
   localparam int          CTRL_IN_DDR   = 2;
   localparam int          CTRL_LOC_INV  = 3;
   localparam int          CTRL_PRESET   = 4;
   localparam int          CTRL_MIRROR   = 5;
   localparam int          CTRL_NC_LSB   = 6;
   localparam int          CTRL_W        = 9;
   // per-element config fields, CFG_W bits per element
   localparam int          CFG_LATCH     = 0;
   localparam int          CFG_ASYNC     = 1;
   localparam int          CFG_FORCE_TO_ONE    = 2;
   localparam int          CFG_INIT_OVR  = 3;
   // inversion mask fields
   localparam int          INV_CLK_LSB   = 0;
   localparam int          INV_CE_LSB    = 4;
   localparam int          INV_FORCE     = 7;
   localparam int          INV_REV       = 8;
   localparam int          INV_D_LSB     = 9;
   localparam int          INV_PAD       = 13;
   localparam int          INV_W         = 14;
   // status fields
   localparam int          STAT_PAD_OUT  = 6;
   localparam int          STAT_PAD_OE   = 7;
   // reset values
   localparam logic [31:0] CTRL_RST      = 32'h0000_01C0;
   localparam logic [31:0] ELEM_RST      = 32'h0000_0000;
   localparam logic [31:0] INIT_RST      = 32'h0000_0000;
   localparam logic [31:0] INV_RST       = 32'h0000_0000;
   // bus answers
   localparam logic [1:0]  RESP_OKAY     = 2'b00;
   localparam logic [1:0]  RESP_SLVERR   = 2'b10;
   // element order: out upper, out lower, oe upper, oe lower, in upper, in lower
   localparam int          ELEM_CLK [NUM_ELEM] = '{0, 1, 0, 1, 2, 3};
   localparam int          ELEM_CE  [NUM_ELEM] = '{0, 0, 1, 1, 2, 2};
endpackage : icsd_pkg

// ### core/icsd_elem.sv
// one storage element: edge flop or level latch with forcing
`timescale 1ns/1ps
module icsd_elem
   import icsd_pkg::*;
(
   input  wire logic i_core_clk,
   input  wire logic i_arst_n,
   input  wire logic i_edge,
   input  wire logic i_gate,
   input  wire logic i_ce,
   input  wire logic i_d,
   input  wire logic i_force,
   input  wire logic i_rev,
   input  wire logic i_latch,
   input  wire logic i_async,
   input  wire logic i_force_to_one,
   input  wire logic i_init,
   input  wire logic i_preset,
   output logic      o_q
);
   logic q_r;
   logic q_nxt;
   logic frc_any;
   logic frc_val;
   logic frc_now;
   logic load_now;

   // forced value; both active gives zero
   assign frc_any  = i_force | i_rev;
   assign frc_val  = (i_force & i_rev) ? 1'b0 :
                     i_force ? i_force_to_one : ~i_force_to_one;
   // async forcing acts at once, sync only at the active edge
   assign frc_now  = frc_any & (i_async | i_edge);
   // flop loads on edge with enable, latch follows while gate and enable
   assign load_now = i_ce & (i_latch ? i_gate : i_edge);

   // next state, preset first
   always_comb begin
      q_nxt = q_r;
      if (i_preset) begin
         q_nxt = i_init;
      end else if (frc_now) begin
         q_nxt = frc_val;
      end else if (load_now) begin
         q_nxt = i_d;
      end
   end

   // state register
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         q_r <= 1'b0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign o_q = q_r;
endmodule : icsd_elem

// ### core/icsd_io_cell.sv
// i/o cell storage pairs with dual-edge muxes and axi4-lite config
`timescale 1ns/1ps
// Function
// - three element pairs; each element is an edge flop or a latch
// - flop loads data only on its active clock edge with enable
// - latch is transparent while enabled, output follows data
// - an unconnected enable counts as always asserted
// - force line drives one when set chosen, zero when reset chosen
// - per element, forcing acts at the edge or immediately
// - opposite force drives the value opposite to the force line
// - force and opposite force together give zero
// - upper output and oe share one clock, lower ones the other
// - input upper and lower registers have separate clocks
// - one enable per pair: output, three-state, input
// - one force line and one opposite force drive all six
// - dual-edge output: upper set/reset choice governs lower too
// - dual-edge output turns two registers into bits on both edges
// - local inverter may derive the second clock from the first
// - output enable path supports dual-edge in the same way
// - dual-edge input captures on clock and its inverse alternately
// - dual-edge output can mirror a clock onto the pad
// - every entering signal except the global preset has an absorbed polarity inversion
module icsd_io_cell
   import icsd_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input  wire logic              i_core_clk,
   input  wire logic              i_arst_n,
   // register bus
   input  wire logic [ADDR_W-1:0] i_awaddr,
   input  wire logic              i_awvalid,
   output logic                   o_awready,
   input  wire logic [31:0]       i_wdata,
   input  wire logic [3:0]        i_wstrb,
   input  wire logic              i_wvalid,
   output logic                   o_wready,
   output logic [1:0]             o_bresp,
   output logic                   o_bvalid,
   input  wire logic              i_bready,
   input  wire logic [ADDR_W-1:0] i_araddr,
   input  wire logic              i_arvalid,
   output logic                   o_arready,
   output logic [31:0]            o_rdata,
   output logic [1:0]             o_rresp,
   output logic                   o_rvalid,
   input  wire logic              i_rready,
   // fabric side
   input  wire logic              i_out_upper_d,
   input  wire logic              i_out_lower_d,
   input  wire logic              i_oe_upper_d,
   input  wire logic              i_oe_lower_d,
   input  wire logic              i_output_pair_enable,
   input  wire logic              i_tristate_pair_enable,
   input  wire logic              i_input_pair_enable,
   input  wire logic              i_force_line,
   input  wire logic              i_opposite_force_in,
   input  wire logic              i_global_preset,
   output logic                   o_in_upper_q,
   output logic                   o_in_lower_q,
   // link clocks and pad
   input  wire logic              i_out_upper_clock,
   input  wire logic              i_out_lower_clock,
   input  wire logic              i_input_upper_clock,
   input  wire logic              i_input_lower_clock,
   input  wire logic              i_pad_in,
   output logic                   o_pad_out,
   output logic                   o_pad_oe
);
   if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
      $error("icsd_io_cell: ADDR_W must lie in 8..32");
   end

   logic [CTRL_W-1:0]         ctrl_r;
   logic [NUM_ELEM*CFG_W-1:0] elem_r;
   logic [NUM_ELEM-1:0]       init_r;
   logic [INV_W-1:0]          inv_r;
   logic                      aw_got_r;
   logic                      w_got_r;
   logic [ADDR_W-1:0]         awaddr_r;
   logic [31:0]               wdata_r;
   logic [3:0]                wstrb_r;
   logic                      bvalid_r;
   logic [1:0]                bresp_r;
   logic                      rvalid_r;
   logic [31:0]               rdata_r;
   logic [1:0]                rresp_r;
   logic                      cfg_load_r;
   logic [4:0]                sync1_r;
   logic [4:0]                sync2_r;
   logic [NUM_CLK-1:0]        lvl_prev_r;
   logic                      pad_out_r;
   logic                      oe_val_r;

   // register bus slave
   logic        wr_fire;
   logic        rd_fire;
   logic        wr_hit;
   logic        rd_hit;
   logic [7:0]  wr_off;
   logic [7:0]  rd_off;
   logic [31:0] wmask;
   logic [31:0] wr_val_ctrl;
   logic [31:0] wr_val_elem;
   logic [31:0] wr_val_init;
   logic [31:0] wr_val_inv;
   logic [31:0] rd_val;
   logic [31:0] stat_word;
   logic        preset_wr;

   // channel readiness
   assign o_awready = !aw_got_r && !bvalid_r;
   assign o_wready  = !w_got_r && !bvalid_r;
   assign o_arready = !rvalid_r;
   assign wr_fire   = aw_got_r && w_got_r && !bvalid_r;
   assign rd_fire   = i_arvalid && o_arready;

   // address decode, upper bits zero
   assign wr_off = awaddr_r[7:0];
   assign rd_off = i_araddr[7:0];
   assign wr_hit = (awaddr_r >> 8) == '0 && (wr_off == ADDR_CTRL || wr_off == ADDR_ELEM
                   || wr_off == ADDR_INIT || wr_off == ADDR_INV);
   assign rd_hit = (i_araddr >> 8) == '0 && (rd_off == ADDR_CTRL || rd_off == ADDR_ELEM
                   || rd_off == ADDR_INIT || rd_off == ADDR_INV || rd_off == ADDR_STAT);

   // byte lane merge
   assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   assign wr_val_ctrl = (wdata_r & wmask) | (32'(ctrl_r) & ~wmask);
   assign wr_val_elem = (wdata_r & wmask) | (32'(elem_r) & ~wmask);
   assign wr_val_init = (wdata_r & wmask) | (32'(init_r) & ~wmask);
   assign wr_val_inv  = (wdata_r & wmask) | (32'(inv_r) & ~wmask);
   assign preset_wr   = wr_fire && wr_off == ADDR_CTRL && wr_hit
                        && wstrb_r[0] && wdata_r[CTRL_PRESET];

   // read data select
   assign rd_val = (rd_off == ADDR_CTRL) ? 32'(ctrl_r & ~(CTRL_W'(1) << CTRL_PRESET)) :
                   (rd_off == ADDR_ELEM) ? 32'(elem_r) :
                   (rd_off == ADDR_INIT) ? 32'(init_r) :
                   (rd_off == ADDR_INV)  ? 32'(inv_r)  : stat_word;

   // write channel capture and response
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         awaddr_r <= '0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= i_wdata;
            wstrb_r <= i_wstrb;
         end
         if (wr_fire) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_r && i_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // configuration registers; preset bit self-clears
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctrl_r <= CTRL_RST[CTRL_W-1:0];
         elem_r <= ELEM_RST[NUM_ELEM*CFG_W-1:0];
         init_r <= INIT_RST[NUM_ELEM-1:0];
         inv_r  <= INV_RST[INV_W-1:0];
      end else if (wr_fire && wr_hit) begin
         if (wr_off == ADDR_CTRL) begin
            ctrl_r <= wr_val_ctrl[CTRL_W-1:0] & ~(CTRL_W'(1) << CTRL_PRESET);
         end
         if (wr_off == ADDR_ELEM) begin
            elem_r <= wr_val_elem[NUM_ELEM*CFG_W-1:0];
         end
         if (wr_off == ADDR_INIT) begin
            init_r <= wr_val_init[NUM_ELEM-1:0];
         end
         if (wr_off == ADDR_INV) begin
            inv_r <= wr_val_inv[INV_W-1:0];
         end
      end
   end

   // read channel
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rresp_r  <= RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_hit ? rd_val : 32'h0000_0000;
         rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && i_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign o_bvalid = bvalid_r;
   assign o_bresp  = bresp_r;
   assign o_rvalid = rvalid_r;
   assign o_rdata  = rdata_r;
   assign o_rresp  = rresp_r;

   logic [4:0]         pin_raw;
   logic [NUM_CLK-1:0] clk_pin;
   logic [NUM_CLK-1:0] lvl;
   logic [NUM_CLK-1:0] edge_det;
   logic               pad_in_s;

   assign pin_raw = {i_pad_in, i_input_lower_clock, i_input_upper_clock,
                     i_out_lower_clock, i_out_upper_clock};

   // two-flop synchronisers
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= pin_raw;
         sync2_r <= sync1_r;
      end
   end

   // polarity options, then derived lower clocks
   assign clk_pin  = sync2_r[3:0] ^ inv_r[INV_CLK_LSB +: NUM_CLK];
   assign pad_in_s = sync2_r[4] ^ inv_r[INV_PAD];
   assign lvl[0] = clk_pin[0];
   assign lvl[1] = ctrl_r[CTRL_LOC_INV] ? ~clk_pin[0] : clk_pin[1];
   assign lvl[2] = clk_pin[2];
   assign lvl[3] = ctrl_r[CTRL_IN_DDR] ? ~clk_pin[2] : clk_pin[3];
   assign edge_det = lvl & ~lvl_prev_r;

   // previous clock levels for rising edge finding
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lvl_prev_r <= '0;
      end else begin
         lvl_prev_r <= lvl;
      end
   end

   logic [2:0]          ce_grp;
   logic [NUM_ELEM-1:0] d_in;
   logic [NUM_ELEM-1:0] q;
   logic [NUM_ELEM-1:0] srh_base;
   logic [NUM_ELEM-1:0] srh_eff;
   logic [NUM_ELEM-1:0] init_base;
   logic [NUM_ELEM-1:0] init_eff;
   logic [1:0]          pair_ddr;
   logic                frc;
   logic                opposite_force_in;
   logic                preset;
   logic                mirror;

   // pair enables, unconnected ones held asserted
   assign ce_grp = ({i_input_pair_enable, i_tristate_pair_enable, i_output_pair_enable}
                   ^ inv_r[INV_CE_LSB +: 3]) | ctrl_r[CTRL_NC_LSB +: 3];
   assign frc = i_force_line ^ inv_r[INV_FORCE];
   assign opposite_force_in = i_opposite_force_in ^ inv_r[INV_REV];
   assign preset = cfg_load_r | i_global_preset | preset_wr;
   assign mirror = ctrl_r[CTRL_MIRROR] & ctrl_r[CTRL_OUT_DDR];
   assign pair_ddr = {ctrl_r[CTRL_OE_DDR], ctrl_r[CTRL_OUT_DDR]};

   // data inputs; mirror gives one upper, zero lower
   assign d_in[0] = mirror | (i_out_upper_d ^ inv_r[INV_D_LSB]);
   assign d_in[1] = ~mirror & (i_out_lower_d ^ inv_r[INV_D_LSB + 1]);
   assign d_in[2] = i_oe_upper_d ^ inv_r[INV_D_LSB + 2];
   assign d_in[3] = i_oe_lower_d ^ inv_r[INV_D_LSB + 3];
   assign d_in[4] = pad_in_s;
   assign d_in[5] = pad_in_s;

   // loads initial values once after reset release
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cfg_load_r <= 1'b1;
      end else begin
         cfg_load_r <= 1'b0;
      end
   end

   // per-element options and instances
   for (genvar e = 0; e < NUM_ELEM; e++) begin : g_elem
      localparam int PB = e - (e % 2);
      assign srh_base[e]  = elem_r[e*CFG_W + CFG_FORCE_TO_ONE];
      assign init_base[e] = elem_r[e*CFG_W + CFG_INIT_OVR] ? init_r[e] : srh_eff[e];
      if (e < 4) begin : g_pair
         assign srh_eff[e]  = pair_ddr[e/2] ? srh_base[PB] : srh_base[e];
         assign init_eff[e] = pair_ddr[e/2] ? (init_base[PB] & init_base[PB+1])
                                            : init_base[e];
      end else begin : g_single
         assign srh_eff[e]  = srh_base[e];
         assign init_eff[e] = init_base[e];
      end
      icsd_elem u_elem (
         .i_core_clk (i_core_clk),
         .i_arst_n   (i_arst_n),
         .i_edge     (edge_det[ELEM_CLK[e]]),
         .i_gate     (lvl[ELEM_CLK[e]]),
         .i_ce       (ce_grp[ELEM_CE[e]]),
         .i_d        (d_in[e]),
         .i_force    (frc),
         .i_rev      (opposite_force_in),
         .i_latch    (elem_r[e*CFG_W + CFG_LATCH]),
         .i_async    (elem_r[e*CFG_W + CFG_ASYNC]),
         .i_force_to_one   (srh_eff[e]),
         .i_init     (init_eff[e]),
         .i_preset   (preset),
         .o_q        (q[e])
      );
   end

   // dual-edge muxes toward the pad
   logic pad_nxt;
   logic oe_nxt;

   // upper, lower or hold by clock level
   assign pad_nxt = !ctrl_r[CTRL_OUT_DDR] ? q[0] :
                    lvl[0] ? q[0] : lvl[1] ? q[1] : pad_out_r;
   assign oe_nxt  = !ctrl_r[CTRL_OE_DDR] ? q[2] :
                    lvl[0] ? q[2] : lvl[1] ? q[3] : oe_val_r;

   // registered pad drive, oe value high releases
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pad_out_r <= 1'b0;
         oe_val_r  <= 1'b1;
      end else begin
         pad_out_r <= pad_nxt;
         oe_val_r  <= oe_nxt;
      end
   end

   assign o_pad_out    = pad_out_r;
   assign o_pad_oe     = ~oe_val_r;
   assign o_in_upper_q = q[4];
   assign o_in_lower_q = q[5];

   // status word: element states and pad drive
   assign stat_word = {24'h00_0000, ~oe_val_r, pad_out_r, q};
endmodule : icsd_io_cell

// ### tb/icsd_checker.sv
// bus handshake and preset assertions at the cell's ports
`timescale 1ns/1ps
module icsd_checker
   import icsd_pkg::*;
(
   input  wire logic        i_core_clk,
   input  wire logic        i_arst_n,
   input  wire logic        i_awvalid,
   input  wire logic        o_awready,
   input  wire logic        i_wvalid,
   input  wire logic        o_wready,
   input  wire logic [1:0]  o_bresp,
   input  wire logic        o_bvalid,
   input  wire logic        i_bready,
   input  wire logic        i_arvalid,
   input  wire logic        o_arready,
   input  wire logic [31:0] o_rdata,
   input  wire logic [1:0]  o_rresp,
   input  wire logic        o_rvalid,
   input  wire logic        i_rready,
   input  wire logic        i_global_preset,
   input  wire logic        o_in_upper_q,
   input  wire logic        o_in_lower_q
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_arst_n);
   // answers stand until taken, channels refused meanwhile
   chk_b_stands: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("bvalid dropped");
   chk_r_stands: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("rvalid dropped");
   chk_aw_refused: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write taken early");
   chk_ar_refused: assert property (o_rvalid |-> !o_arready)
      else $error("read taken early");
   // answer timing
   chk_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready
      |-> ##[1:2] o_bvalid)
      else $error("write answer late");
   chk_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read answer late");
   chk_read_cause: assert property ($rose(o_rvalid) |-> $past(i_arvalid && o_arready))
      else $error("rvalid uncaused");
   chk_error_zero: assert property (o_rvalid && o_rresp == RESP_SLVERR |-> o_rdata == '0)
      else $error("error read has data");
   // held preset keeps input states constant
   chk_preset_hold: assert property (i_global_preset && $past(i_global_preset) &&
      $past(i_global_preset, 2) && $past(i_arst_n, 2)
      |=> $stable(o_in_upper_q) && $stable(o_in_lower_q))
      else $error("state moved under preset");
endmodule : icsd_checker

bind icsd_io_cell icsd_checker u_chk (.i_core_clk, .i_arst_n, .i_awvalid, .o_awready,
   .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_arvalid, .o_arready,
   .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_global_preset, .o_in_upper_q,
   .o_in_lower_q);

// ### tb/icsd_fabric_model.sv
// far-side model: link clock pair and double-rate pad data
`timescale 1ns/1ps
module icsd_fabric_model
(
   output logic o_uclk,
   output logic o_lclk,
   output logic o_pad
);
   logic busy;
   // clocks stand still between bursts
   initial begin
      o_uclk = 1'b0;
      o_lclk = 1'b1;
      o_pad  = 1'b0;
      busy   = 1'b0;
   end
   // idle pad wanders so stale values never pass
   always #4 if (!busy) o_pad = ~o_pad;
   // 48 ns periods, pad bit set ahead of each edge
   task automatic run(input int n, input logic hi, input logic lo);
      busy = 1'b1;
      repeat (n) begin
         o_pad = hi;
         #12 o_uclk = 1'b1;
         o_lclk = 1'b0;
         #12 o_pad = lo;
         #12 o_uclk = 1'b0;
         o_lclk = 1'b1;
         #12;
      end
      busy = 1'b0;
   endtask : run
endmodule : icsd_fabric_model

// ### tb/icsd_io_cell_tb_top.sv
// self-checking bench for the i/o cell storage block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
   $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module icsd_io_cell_tb_top
   import icsd_pkg::*;
;
   logic        i_core_clk = 1'b0;
   logic [7:0]  i_awaddr, i_araddr;
   logic [31:0] i_wdata, o_rdata, v;
   logic [3:0]  i_wstrb;
   logic [1:0]  o_bresp, o_rresp;
   logic        i_arst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
   logic        i_out_upper_d, i_out_lower_d, i_oe_upper_d, i_oe_lower_d;
   logic        i_output_pair_enable, i_tristate_pair_enable, i_input_pair_enable;
   logic        i_force_line, i_opposite_force_in, i_global_preset;
   logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic        o_in_upper_q, o_in_lower_q, o_pad_out, o_pad_oe, uclk, lclk, pad;
   int          n_errors = 0, checked = 0, cycles = 0;
   icsd_fabric_model model (.o_uclk(uclk), .o_lclk(lclk), .o_pad(pad));
   icsd_io_cell dut (.i_core_clk, .i_arst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
      .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
      .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_out_upper_d, .i_out_lower_d,
      .i_oe_upper_d, .i_oe_lower_d, .i_output_pair_enable, .i_tristate_pair_enable,
      .i_input_pair_enable, .i_force_line, .i_opposite_force_in, .i_global_preset,
      .o_in_upper_q, .o_in_lower_q, .i_out_upper_clock(uclk), .i_out_lower_clock(lclk),
      .i_input_upper_clock(uclk), .i_input_lower_clock(lclk), .i_pad_in(pad), .o_pad_out,
      .o_pad_oe);
   // core clock and hang guard
   always #2 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_errors++;
         test_done();
      end
   end
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done
   task automatic cyc(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask : cyc
   // bus write, address and data together
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge i_core_clk);
      i_awaddr  <= a;
      i_wdata   <= d;
      i_awvalid <= 1'b1;
      i_wvalid  <= 1'b1;
      do begin
         @(posedge i_core_clk);
         if (o_awready) i_awvalid <= 1'b0;
         if (o_wready) i_wvalid <= 1'b0;
      end while (!o_bvalid);
      i_bready <= 1'b1;
      @(posedge i_core_clk);
      i_bready <= 1'b0;
      `CHK("bresp", er, o_bresp)
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      @(posedge i_core_clk);
      i_araddr  <= a;
      i_arvalid <= 1'b1;
      do begin
         @(posedge i_core_clk);
         if (o_arready) i_arvalid <= 1'b0;
      end while (!o_rvalid);
      i_rready <= 1'b1;
      @(posedge i_core_clk);
      i_rready <= 1'b0;
      d = o_rdata;
      `CHK("rresp", er, o_rresp)
   endtask : rd
   task automatic st(input int b, input logic e, input string n);
      rd(ADDR_STAT, v, RESP_OKAY);
      `CHK(n, e, v[b])
   endtask : st
   task automatic preset();
      i_global_preset <= 1'b1;
      cyc(4);
      i_global_preset <= 1'b0;
      cyc(2);
   endtask : preset
   task automatic t_regs();
      rd(ADDR_CTRL, v, RESP_OKAY);
      `CHK("ctrl reset", CTRL_RST, v)
      rd(ADDR_ELEM, v, RESP_OKAY);
      `CHK("elem reset", ELEM_RST, v)
      rd(ADDR_INV, v, RESP_OKAY);
      `CHK("inv reset", INV_RST, v)
      wr(ADDR_STAT, 32'h0000_00FF, RESP_SLVERR);
      wr(8'h14, 32'h0000_0001, RESP_SLVERR);
      rd(8'h40, v, RESP_SLVERR);
      `CHK("unmapped data", 32'h0000_0000, v)
      i_wstrb <= 4'h2;
      wr(ADDR_INV, 32'h0000_FFFF, RESP_OKAY);
      i_wstrb <= 4'hF;
      rd(ADDR_INV, v, RESP_OKAY);
      `CHK("inv byte lane", 32'h0000_3F00, v)
      wr(ADDR_INV, 32'h0000_0000, RESP_OKAY);
      $display("test regs done");
   endtask : t_regs
   task automatic t_init();
      wr(ADDR_ELEM, 32'h0000_000C, RESP_OKAY);
      wr(ADDR_INIT, 32'h0000_0000, RESP_OKAY);
      preset();
      st(0, 1'b0, "init override");
      wr(ADDR_ELEM, 32'h0000_0004, RESP_OKAY);
      preset();
      st(0, 1'b1, "init from set choice");
      // sync forcing waits for the clock edge
      wr(ADDR_ELEM, 32'h0000_0000, RESP_OKAY);
      i_out_upper_d <= 1'b1;
      i_force_line  <= 1'b1;
      cyc(8);
      st(0, 1'b1, "sync force before edge");
      model.run(1, 1'b0, 1'b0);
      st(0, 1'b0, "sync force at edge");
      i_force_line <= 1'b0;
      $display("test init done");
   endtask : t_init
   task automatic t_force();
      wr(ADDR_ELEM, 32'h0002_0006, RESP_OKAY);
      for (int k = 1; k < 4; k++) begin
         i_force_line        <= k[1];
         i_opposite_force_in <= k[0];
         cyc(4);
         rd(ADDR_STAT, v, RESP_OKAY);
         `CHK("force set elem", k == 2, v[0])
         `CHK("force clr elem", k == 1, v[4])
      end
      i_force_line        <= 1'b0;
      i_opposite_force_in <= 1'b0;
      $display("test force done");
   endtask : t_force
   task automatic t_flop();
      wr(ADDR_ELEM, 32'h0000_0000, RESP_OKAY);
      wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
      preset();
      {i_oe_upper_d, i_tristate_pair_enable, i_output_pair_enable} <= 3'b110;
      model.run(1, 1'b0, 1'b0);
      st(0, 1'b0, "flop gated off");
      st(2, 1'b1, "flop loads");
      wr(ADDR_CTRL, CTRL_RST, RESP_OKAY);
      model.run(1, 1'b0, 1'b0);
      st(0, 1'b1, "open enable");
      $display("test flop done");
   endtask : t_flop
   task automatic t_latch();
      wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
      wr(ADDR_ELEM, 32'h0000_0010, RESP_OKAY);
      {i_output_pair_enable, i_out_lower_d} <= 2'b11;
      st(1, 1'b1, "latch open high");
      i_out_lower_d <= 1'b0;
      st(1, 1'b0, "latch open low");
      {i_output_pair_enable, i_out_lower_d} <= 2'b01;
      st(1, 1'b0, "latch shut");
      $display("test latch done");
   endtask : t_latch
   // d holds {out upper, out lower, oe upper, oe lower}, x the expected {pad high, pad low, oe high, oe low} phases
   task automatic t_ddr(input logic [31:0] c, input logic [3:0] d, input logic [3:0] x);
      wr(ADDR_ELEM, 32'h0000_0000, RESP_OKAY);
      wr(ADDR_CTRL, c, RESP_OKAY);
      {i_out_upper_d, i_out_lower_d, i_oe_upper_d, i_oe_lower_d} <= d;
      fork
         model.run(4, 1'b0, 1'b0);
         begin
            repeat (2) @(posedge uclk);
            cyc(5);
            #1;
            `CHK("pad high phase", x[3], o_pad_out)
            `CHK("oe high phase", x[1], o_pad_oe)
            @(posedge lclk);
            cyc(5);
            #1;
            `CHK("pad low phase", x[2], o_pad_out)
            `CHK("oe low phase", x[0], o_pad_oe)
         end
      join
      $display("test dual edge out done");
   endtask : t_ddr
   task automatic t_in(input logic [31:0] inv, input logic hi, input logic lo);
      wr(ADDR_INV, inv, RESP_OKAY);
      model.run(2, hi, lo);
      cyc(4);
      `CHK("in upper", hi ^ inv[INV_PAD], o_in_upper_q)
      `CHK("in lower", lo ^ inv[INV_PAD], o_in_lower_q)
      $display("test dual edge in done");
   endtask : t_in
   // main sequence
   initial begin
      {i_awaddr, i_araddr, i_wdata, i_awvalid, i_wvalid, i_bready, i_arvalid} = '0;
      {i_rready, i_out_upper_d, i_out_lower_d, i_oe_upper_d, i_oe_lower_d} = '0;
      {i_output_pair_enable, i_tristate_pair_enable, i_force_line} = '0;
      {i_opposite_force_in, i_global_preset, i_arst_n} = '0;
      i_input_pair_enable = 1'b1;
      i_wstrb = 4'hF;
      cyc(16);
      i_arst_n <= 1'b1;
      cyc(2);
      t_regs();
      t_init();
      t_force();
      t_flop();
      t_latch();
      t_ddr(32'h0000_01C3, 4'b1001, 4'b1010);
      t_ddr(32'h0000_01C3, 4'b0110, 4'b0101);
      t_ddr(32'h0000_01EF, 4'b0110, 4'b1001);
      t_in(32'h0000_0000, 1'b1, 1'b0);
      t_in(32'h0000_0000, 1'b0, 1'b1);
      t_in(32'h0000_2000, 1'b1, 1'b0);
      test_done();
   end
endmodule : icsd_io_cell_tb_top
